// File: core/wst_pkg.sv
// constants of the weekly sequence run timers
package wst_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int NUM_TIMERS = 4;
  localparam int NUM_FIELDS = 5;
  localparam int IDX_W      = 14;
  localparam int TIME_W     = 11;

  // ****************************************
  // register indices, byte address is four times the index
  // ****************************************
  localparam logic [13:0] IDX_T1_START  = 14'h3206;
  localparam logic [13:0] IDX_T1_STOP   = 14'h3207;
  localparam logic [13:0] IDX_T1_DAY    = 14'h3208;
  localparam logic [13:0] IDX_T1_ACTION = 14'h3209;
  localparam logic [13:0] IDX_T1_REF    = 14'h320a;
  localparam logic [13:0] IDX_T2_START  = 14'h320b;
  localparam logic [13:0] IDX_T2_STOP   = 14'h320c;
  localparam logic [13:0] IDX_T2_DAY    = 14'h320d;
  localparam logic [13:0] IDX_T2_ACTION = 14'h320e;
  localparam logic [13:0] IDX_T2_REF    = 14'h320f;
  localparam logic [13:0] IDX_T3_START  = 14'h3210;
  localparam logic [13:0] IDX_T3_STOP   = 14'h3211;
  localparam logic [13:0] IDX_T3_DAY    = 14'h3212;
  localparam logic [13:0] IDX_T3_ACTION = 14'h3213;
  localparam logic [13:0] IDX_T3_REF    = 14'h3214;
  localparam logic [13:0] IDX_T4_START  = 14'h3215;
  localparam logic [13:0] IDX_T4_STOP   = 14'h3216;
  localparam logic [13:0] IDX_T4_DAY    = 14'h3217;
  localparam logic [13:0] IDX_T4_ACTION = 14'h3218;
  localparam logic [13:0] IDX_T4_REF    = 14'h3219;
  localparam logic [13:0] IDX_STATUS    = 14'h3240;
  localparam logic [13:0] IDX_DRIVE     = 14'h3241;

  // ****************************************
  // field codes and reset values
  // ****************************************
  typedef enum logic [2:0] {
    WST_FLD_START  = 3'h0,
    WST_FLD_STOP   = 3'h1,
    WST_FLD_DAY    = 3'h2,
    WST_FLD_ACTION = 3'h3,
    WST_FLD_REF    = 3'h4
  } wst_field_t;

  localparam logic [10:0] MINUTES_PER_DAY = 11'h5a0;
  localparam logic [10:0] TIME_RESET      = 11'h000;
  localparam logic [3:0]  DAY_OFF         = 4'h0;
  localparam logic [3:0]  DAY_ALL         = 4'h1;
  localparam logic [3:0]  DAY_WORKWEEK    = 4'h2;
  localparam logic [3:0]  DAY_WEEKEND     = 4'h3;
  localparam logic [3:0]  DAY_MONDAY      = 4'h4;
  localparam logic [3:0]  DAY_LAST        = 4'ha;
  localparam logic [2:0]  WEEKDAY_SAT     = 3'h5;
  localparam logic [2:0]  WEEKDAY_SUN     = 3'h6;
  localparam logic [1:0]  ACT_DOUT        = 2'h0;
  localparam logic [1:0]  ACT_RUN         = 2'h1;
  localparam logic [1:0]  ACT_RUN_NOPI    = 2'h2;
  localparam logic [2:0]  REF_RESET       = 3'h0;

endpackage

// File: core/wst_timers.sv
// four weekly sequence run timers with an apb register slave
//
// The implementer's own choice: the APB register port.
module wst_timers (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // real-time clock, weekday 0 is monday, minute of day 0 to 1439
  input  wire logic [2:0]  rtcWeekday,
  input  wire logic [10:0] rtcMinute,
  // drive controls
  output logic [3:0]       timerActive,
  output logic             digitalOut,
  output logic             runRequest,
  output logic             piDisable,
  output logic             refValid,
  output logic [2:0]       refSource
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [13:0] fieldIndex(input int t, input int f);
    logic [13:0] tab [0:19];
    tab = '{wst_pkg::IDX_T1_START, wst_pkg::IDX_T1_STOP, wst_pkg::IDX_T1_DAY,
            wst_pkg::IDX_T1_ACTION, wst_pkg::IDX_T1_REF,
            wst_pkg::IDX_T2_START, wst_pkg::IDX_T2_STOP, wst_pkg::IDX_T2_DAY,
            wst_pkg::IDX_T2_ACTION, wst_pkg::IDX_T2_REF,
            wst_pkg::IDX_T3_START, wst_pkg::IDX_T3_STOP, wst_pkg::IDX_T3_DAY,
            wst_pkg::IDX_T3_ACTION, wst_pkg::IDX_T3_REF,
            wst_pkg::IDX_T4_START, wst_pkg::IDX_T4_STOP, wst_pkg::IDX_T4_DAY,
            wst_pkg::IDX_T4_ACTION, wst_pkg::IDX_T4_REF};
    return tab[t * wst_pkg::NUM_FIELDS + f];
  endfunction

  function automatic logic dayMatch(input logic [3:0] code, input logic [2:0] wd);
    logic weekend;
    weekend = (wd == wst_pkg::WEEKDAY_SAT) || (wd == wst_pkg::WEEKDAY_SUN);
    unique case (code)
      wst_pkg::DAY_OFF:      return 1'b0;
      wst_pkg::DAY_ALL:      return 1'b1;
      wst_pkg::DAY_WORKWEEK: return !weekend;
      wst_pkg::DAY_WEEKEND:  return weekend;
      default:               return (code >= wst_pkg::DAY_MONDAY) && (code <= wst_pkg::DAY_LAST)
                                    && ({1'b0, wd} == code - wst_pkg::DAY_MONDAY);
    endcase
  endfunction

  // ****************************************
  // storage
  // ****************************************
  logic [10:0] timerStart  [wst_pkg::NUM_TIMERS];
  logic [10:0] timerStop   [wst_pkg::NUM_TIMERS];
  logic [3:0]  timerDay    [wst_pkg::NUM_TIMERS];
  logic [1:0]  timerAction [wst_pkg::NUM_TIMERS];
  logic [2:0]  timerRef    [wst_pkg::NUM_TIMERS];

  // ****************************************
  // bus decode
  // ****************************************
  wire logic [13:0] busIdx   = paddr[15:2];
  wire logic        setup    = psel && !penable;
  wire logic        wrAccess = psel && penable && pwrite;
  wire logic [10:0] wrTime   = pwdata[10:0];
  wire logic        wrHigh   = |pwdata[31:11];
  wire logic        timeOk   = !wrHigh && (wrTime <= wst_pkg::MINUTES_PER_DAY);
  wire logic        dayOk    = (pwdata[31:4] == 28'h0) && (pwdata[3:0] <= wst_pkg::DAY_LAST);
  wire logic        actOk    = (pwdata[31:2] == 30'h0) && (pwdata[1:0] <= wst_pkg::ACT_RUN_NOPI);
  wire logic        refOk    = (pwdata[31:3] == 29'h0);

  logic [wst_pkg::NUM_TIMERS-1:0] hitStart;
  logic [wst_pkg::NUM_TIMERS-1:0] hitStop;
  logic [wst_pkg::NUM_TIMERS-1:0] hitDay;
  logic [wst_pkg::NUM_TIMERS-1:0] hitAction;
  logic [wst_pkg::NUM_TIMERS-1:0] hitRef;

  genvar g;
  generate
    for (g = 0; g < wst_pkg::NUM_TIMERS; g++) begin : g_hit
      assign hitStart[g]  = busIdx == fieldIndex(g, wst_pkg::WST_FLD_START);
      assign hitStop[g]   = busIdx == fieldIndex(g, wst_pkg::WST_FLD_STOP);
      assign hitDay[g]    = busIdx == fieldIndex(g, wst_pkg::WST_FLD_DAY);
      assign hitAction[g] = busIdx == fieldIndex(g, wst_pkg::WST_FLD_ACTION);
      assign hitRef[g]    = busIdx == fieldIndex(g, wst_pkg::WST_FLD_REF);
    end
  endgenerate

  wire logic hitTimer  = |{hitStart, hitStop, hitDay, hitAction, hitRef};
  wire logic hitStatus = busIdx == wst_pkg::IDX_STATUS;
  wire logic hitDrive  = busIdx == wst_pkg::IDX_DRIVE;
  wire logic mapped    = hitTimer || hitStatus || hitDrive;

  // ****************************************
  // read mux
  // ****************************************
  logic [31:0] readWord;
  always_comb begin
    readWord = 32'h0;
    for (int t = 0; t < wst_pkg::NUM_TIMERS; t++) begin
      if (hitStart[t]) readWord = {21'h0, timerStart[t]};
      if (hitStop[t]) readWord = {21'h0, timerStop[t]};
      if (hitDay[t]) readWord = {28'h0, timerDay[t]};
      if (hitAction[t]) readWord = {30'h0, timerAction[t]};
      if (hitRef[t]) readWord = {29'h0, timerRef[t]};
    end
    if (hitStatus) readWord = {28'h0, timerActive};
    if (hitDrive) readWord = {26'h0, refSource, refValid, piDisable, runRequest};
  end

  // read data and error are latched in the setup cycle so they come from flops
  assign pready = 1'b1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0 : readWord;
      pslverr <= !mapped;
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  // an illegal value is dropped whole rather than clipped, so software sees
  // its old setting on read-back instead of a silently altered one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int t = 0; t < wst_pkg::NUM_TIMERS; t++) begin
        timerStart[t]  <= wst_pkg::TIME_RESET;
        timerStop[t]   <= wst_pkg::TIME_RESET;
        timerDay[t]    <= wst_pkg::DAY_OFF;
        timerAction[t] <= wst_pkg::ACT_DOUT;
        timerRef[t]    <= wst_pkg::REF_RESET;
      end
    end else if (wrAccess) begin
      for (int t = 0; t < wst_pkg::NUM_TIMERS; t++) begin
        if (hitStart[t] && timeOk) timerStart[t] <= wrTime;
        if (hitStop[t] && timeOk) timerStop[t] <= wrTime;
        if (hitDay[t] && dayOk) timerDay[t] <= pwdata[3:0];
        if (hitAction[t] && actOk) timerAction[t] <= pwdata[1:0];
        if (hitRef[t] && refOk) timerRef[t] <= pwdata[2:0];
      end
    end
  end

  // ****************************************
  // window evaluation
  // ****************************************
  logic [wst_pkg::NUM_TIMERS-1:0] next_timerActive;
  logic [wst_pkg::NUM_TIMERS-1:0] runsDrive;
  generate
    for (g = 0; g < wst_pkg::NUM_TIMERS; g++) begin : g_win
      assign next_timerActive[g] = (timerStart[g] <= timerStop[g])
                                   && dayMatch(timerDay[g], rtcWeekday)
                                   && (rtcMinute >= timerStart[g])
                                   && (rtcMinute < timerStop[g]);
      assign runsDrive[g] = next_timerActive[g] && (timerAction[g] != wst_pkg::ACT_DOUT);
    end
  endgenerate

  // lowest numbered running timer owns the reference when several overlap
  logic [2:0] next_refSource;
  logic       next_piDisable;
  always_comb begin
    next_refSource = wst_pkg::REF_RESET;
    next_piDisable = 1'b0;
    for (int t = wst_pkg::NUM_TIMERS - 1; t >= 0; t--) begin
      if (runsDrive[t]) begin
        next_refSource = timerRef[t];
        next_piDisable = timerAction[t] == wst_pkg::ACT_RUN_NOPI;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timerActive <= 4'h0;
      digitalOut  <= 1'b0;
      runRequest  <= 1'b0;
      piDisable   <= 1'b0;
      refValid    <= 1'b0;
      refSource   <= wst_pkg::REF_RESET;
    end else begin
      timerActive <= next_timerActive;
      digitalOut  <= |next_timerActive;
      runRequest  <= |runsDrive;
      piDisable   <= next_piDisable;
      refValid    <= |runsDrive;
      refSource   <= next_refSource;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  generate
    for (g = 0; g < wst_pkg::NUM_TIMERS; g++) begin : g_chk
      property p_time_range;
        @(posedge clk) disable iff (!rst_n)
        timerStart[g] <= wst_pkg::MINUTES_PER_DAY && timerStop[g] <= wst_pkg::MINUTES_PER_DAY;
      endproperty
      a_time_range: assert property (p_time_range) else $error("time out of range");

      property p_reversed_off;
        @(posedge clk) disable iff (!rst_n)
        (timerStart[g] > timerStop[g]) |=> !timerActive[g];
      endproperty
      a_reversed_off: assert property (p_reversed_off) else $error("reversed window active");

      property p_day_off;
        @(posedge clk) disable iff (!rst_n)
        (timerDay[g] == wst_pkg::DAY_OFF) |=> !timerActive[g];
      endproperty
      a_day_off: assert property (p_day_off) else $error("disabled day code active");

      property p_single_day;
        @(posedge clk) disable iff (!rst_n)
        (timerDay[g] >= wst_pkg::DAY_MONDAY) ##1 timerActive[g]
          |-> {1'b0, $past(rtcWeekday)} == $past(timerDay[g]) - wst_pkg::DAY_MONDAY;
      endproperty
      a_single_day: assert property (p_single_day) else $error("wrong weekday active");

      property p_window;
        @(posedge clk) disable iff (!rst_n)
        timerActive[g] |-> $past(rtcMinute) >= $past(timerStart[g])
                           && $past(rtcMinute) < $past(timerStop[g]);
      endproperty
      a_window: assert property (p_window) else $error("active outside window");

      property p_daily_in_window;
        @(posedge clk) disable iff (!rst_n)
        (timerDay[g] == wst_pkg::DAY_ALL && timerStart[g] <= rtcMinute
         && rtcMinute < timerStop[g]) |=> timerActive[g];
      endproperty
      a_daily_in_window: assert property (p_daily_in_window) else $error("daily timer idle");

      property p_workweek_off;
        @(posedge clk) disable iff (!rst_n)
        (timerDay[g] == wst_pkg::DAY_WORKWEEK && (rtcWeekday == wst_pkg::WEEKDAY_SAT
         || rtcWeekday == wst_pkg::WEEKDAY_SUN)) |=> !timerActive[g];
      endproperty
      a_workweek_off: assert property (p_workweek_off) else $error("workweek on weekend");

      property p_weekend_off;
        @(posedge clk) disable iff (!rst_n)
        (timerDay[g] == wst_pkg::DAY_WEEKEND && rtcWeekday != wst_pkg::WEEKDAY_SAT
         && rtcWeekday != wst_pkg::WEEKDAY_SUN) |=> !timerActive[g];
      endproperty
      a_weekend_off: assert property (p_weekend_off) else $error("weekend on weekday");

      property p_codes_legal;
        @(posedge clk) disable iff (!rst_n)
        timerDay[g] <= wst_pkg::DAY_LAST && timerAction[g] <= wst_pkg::ACT_RUN_NOPI;
      endproperty
      a_codes_legal: assert property (p_codes_legal) else $error("illegal code stored");

      property p_start_write;
        @(posedge clk) disable iff (!rst_n)
        (wrAccess && hitStart[g] && timeOk) |=> timerStart[g] == $past(wrTime);
      endproperty
      a_start_write: assert property (p_start_write) else $error("start not written");

      property p_stop_write;
        @(posedge clk) disable iff (!rst_n)
        (wrAccess && hitStop[g] && timeOk) |=> timerStop[g] == $past(wrTime);
      endproperty
      a_stop_write: assert property (p_stop_write) else $error("stop not written");

      property p_bad_time_kept;
        @(posedge clk) disable iff (!rst_n)
        (wrAccess && (hitStart[g] || hitStop[g]) && !timeOk)
          |=> $stable(timerStart[g]) && $stable(timerStop[g]);
      endproperty
      a_bad_time_kept: assert property (p_bad_time_kept) else $error("bad time stored");

      property p_bad_day_kept;
        @(posedge clk) disable iff (!rst_n)
        (wrAccess && hitDay[g] && !dayOk) |=> $stable(timerDay[g]);
      endproperty
      a_bad_day_kept: assert property (p_bad_day_kept) else $error("bad day stored");

      property p_bad_action_kept;
        @(posedge clk) disable iff (!rst_n)
        (wrAccess && hitAction[g] && !actOk) |=> $stable(timerAction[g]);
      endproperty
      a_bad_action_kept: assert property (p_bad_action_kept) else $error("bad action");
    end
  endgenerate

  property p_dout_only;
    @(posedge clk) disable iff (!rst_n)
    (runsDrive == 4'h0) |=> !runRequest && !refValid && !piDisable;
  endproperty
  a_dout_only: assert property (p_dout_only) else $error("run without run action");

  property p_run_follows;
    @(posedge clk) disable iff (!rst_n)
    (|runsDrive) |=> runRequest && refValid && digitalOut;
  endproperty
  a_run_follows: assert property (p_run_follows) else $error("run not requested");

  property p_ref_owner;
    @(posedge clk) disable iff (!rst_n)
    runsDrive[0] |=> refSource == $past(timerRef[0])
                     && piDisable == ($past(timerAction[0]) == wst_pkg::ACT_RUN_NOPI);
  endproperty
  a_ref_owner: assert property (p_ref_owner) else $error("reference not from timer one");

  property p_dout_any;
    @(posedge clk) disable iff (!rst_n)
    (|next_timerActive) |=> digitalOut;
  endproperty
  a_dout_any: assert property (p_dout_any) else $error("digital output missing");

  property p_all_idle;
    @(posedge clk) disable iff (!rst_n)
    (next_timerActive == 4'h0)
      |=> !digitalOut && !runRequest && refSource == wst_pkg::REF_RESET;
  endproperty
  a_all_idle: assert property (p_all_idle) else $error("output while idle");

  // ****************************************
  // bus checks
  // ****************************************
  property p_unmapped_err;
    @(posedge clk) disable iff (!rst_n)
    (setup && !mapped) |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped index accepted");

endmodule

// File: dv/wst_timers_tb.sv
// self-checking testbench for the weekly sequence run timers
module wst_timers_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // signals
  // ****************************************
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  rtcWeekday;
  logic [10:0] rtcMinute;
  logic [3:0]  timerActive;
  logic        digitalOut;
  logic        runRequest;
  logic        piDisable;
  logic        refValid;
  logic [2:0]  refSource;
  int          err_total;
  int          checks;
  logic [31:0] rdData;
  logic        rdErr;

  wst_timers wst_timers_inst (
    .clk        (clk),
    .rst_n      (rst_n),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .rtcWeekday (rtcWeekday),
    .rtcMinute  (rtcMinute),
    .timerActive(timerActive),
    .digitalOut (digitalOut),
    .runRequest (runRequest),
    .piDisable  (piDisable),
    .refValid   (refValid),
    .refSource  (refSource)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] data);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= data;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) err_total++;
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next setup never lands in the same time step
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp, input logic expErr);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rdData, exp);
    chk({31'h0, rdErr}, {31'h0, expErr});
  endtask

  // set the clock inputs and compare all drive outputs once they settle
  task automatic rtc_chk(input logic [2:0] wd, input logic [10:0] mn, input logic [10:0] exp);
    rtcWeekday <= wd;
    rtcMinute  <= mn;
    repeat (2) @(posedge clk);
    #1;
    chk({21'h0, timerActive, digitalOut, runRequest, piDisable, refValid, refSource},
        {21'h0, exp});
    @(posedge clk);
  endtask

  function automatic logic day_hit(input int code, input int wd);
    if (code == 1) return 1'b1;
    if (code == 2) return wd < 5;
    if (code == 3) return wd >= 5;
    if (code >= 4 && code <= 10) return wd == code - 4;
    return 1'b0;
  endfunction

  task automatic stop_test;
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************
  // clock, reset and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (50000) @(posedge clk);
    err_total++;
    stop_test();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    int i;
    int c;
    int w;
    err_total = 0;
    checks = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    rtcWeekday = 3'h0;
    rtcMinute = 11'h000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // every timer field comes out of reset as zero
    for (i = 0; i < 20; i++) rd_chk(wst_pkg::IDX_T1_START + 14'(i), 32'h0, 1'b0);
    rd_chk(14'h3220, 32'h0, 1'b1);
    // timer 1 window, boundaries at both ends
    apb(1'b1, wst_pkg::IDX_T1_START, 32'h3c);
    apb(1'b1, wst_pkg::IDX_T1_STOP, 32'h78);
    apb(1'b1, wst_pkg::IDX_T1_ACTION, 32'h1);
    apb(1'b1, wst_pkg::IDX_T1_REF, 32'h5);
    rtc_chk(3'h2, 11'h03c, 11'h000);
    apb(1'b1, wst_pkg::IDX_T1_DAY, 32'h1);
    rtc_chk(3'h2, 11'h03b, 11'h000);
    rtc_chk(3'h2, 11'h03c, {4'h1, 4'hd, 3'h5});
    rtc_chk(3'h2, 11'h077, {4'h1, 4'hd, 3'h5});
    rtc_chk(3'h2, 11'h078, 11'h000);
    apb(1'b1, wst_pkg::IDX_T1_DAY, 32'h0);
    // every day code against every weekday, digital output only
    apb(1'b1, wst_pkg::IDX_T2_STOP, 32'h5a0);
    apb(1'b1, wst_pkg::IDX_T2_REF, 32'h7);
    for (c = 0; c <= 10; c++) begin
      apb(1'b1, wst_pkg::IDX_T2_DAY, 32'(c));
      for (w = 0; w < 7; w++) begin
        rtc_chk(3'(w), 11'h2bc, {2'b00, day_hit(c, w), 1'b0, day_hit(c, w), 6'h00});
      end
    end
    apb(1'b1, wst_pkg::IDX_T2_DAY, 32'h0);
    // start above stop keeps the timer off
    apb(1'b1, wst_pkg::IDX_T3_START, 32'hc8);
    apb(1'b1, wst_pkg::IDX_T3_STOP, 32'h64);
    apb(1'b1, wst_pkg::IDX_T3_DAY, 32'h1);
    apb(1'b1, wst_pkg::IDX_T3_ACTION, 32'h1);
    rtc_chk(3'h0, 11'h096, 11'h000);
    rtc_chk(3'h0, 11'h032, 11'h000);
    // last minute before 24:00 with run and pi off, every reference code
    apb(1'b1, wst_pkg::IDX_T4_START, 32'h578);
    apb(1'b1, wst_pkg::IDX_T4_STOP, 32'h5a0);
    rd_chk(wst_pkg::IDX_T4_STOP, 32'h5a0, 1'b0);
    apb(1'b1, wst_pkg::IDX_T4_DAY, 32'h1);
    apb(1'b1, wst_pkg::IDX_T4_ACTION, 32'h2);
    for (c = 0; c < 8; c++) begin
      apb(1'b1, wst_pkg::IDX_T4_REF, 32'(c));
      rtc_chk(3'h6, 11'h59f, {4'h8, 4'hf, 3'(c)});
    end
    rd_chk(wst_pkg::IDX_STATUS, 32'h8, 1'b0);
    rd_chk(wst_pkg::IDX_DRIVE, 32'h3f, 1'b0);
    rtc_chk(3'h6, 11'h577, 11'h000);
    // out of range day code, start time and action code are dropped
    apb(1'b1, wst_pkg::IDX_T4_DAY, 32'hb);
    rd_chk(wst_pkg::IDX_T4_DAY, 32'h1, 1'b0);
    apb(1'b1, wst_pkg::IDX_T4_START, 32'h5a1);
    rd_chk(wst_pkg::IDX_T4_START, 32'h578, 1'b0);
    apb(1'b1, wst_pkg::IDX_T4_ACTION, 32'h3);
    rd_chk(wst_pkg::IDX_T4_ACTION, 32'h2, 1'b0);
    stop_test();
  end
endmodule
